// [design/rspctl_defs.vh]
// rspctl_defs.vh: offsets, field positions, reset values for the respiration control registers
// assumes byte addressing on a 32-bit APB word bus
`ifndef RSPCTL_DEFS_VH
`define RSPCTL_DEFS_VH
`define RSPCTL_IDX_ONE       4'h9
`define RSPCTL_IDX_TWO       4'ha
`define RSPCTL_ADDR_W        8
`define RSPCTL_ONE_DEMOD     7
`define RSPCTL_ONE_MOD       6
`define RSPCTL_ONE_PH_HI     5
`define RSPCTL_ONE_PH_LO     2
`define RSPCTL_ONE_FIXED     1
`define RSPCTL_ONE_SRC       0
`define RSPCTL_TWO_CAL       7
`define RSPCTL_TWO_FREQ      2
`define RSPCTL_TWO_REF       1
`define RSPCTL_TWO_FIXED     0
`define RSPCTL_ONE_RESET     8'h02
`define RSPCTL_TWO_RESET     8'h03
`define RSPCTL_ONE_FIXMASK   8'h02
`define RSPCTL_TWO_KEEPMASK  8'h86
`define RSPCTL_TWO_SETMASK   8'h01
`define RSPCTL_PH_STEP32     8'h01
`define RSPCTL_PH_STEP64     8'h02
`endif

// [design/rspctl_phase_map.v]
// rspctl_phase_map.v: maps phase code and clock rate to a phase step count (units of 11.25 deg)
// assumes synchronous inputs, one clock
`timescale 1ns/100ps
`include "rspctl_defs.vh"
module rspctl_phase_map (
  input  wire       clk,
  input  wire       sys_rst,
  input  wire [3:0] phaseCode,
  input  wire       fastClk,
  output reg  [3:0] phaseSteps
);
  wire [3:0] stepsNxt;
  // msb dropped at 64 kHz, each step doubles
  assign stepsNxt = fastClk ? {phaseCode[2:0], 1'b0} : phaseCode;
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      phaseSteps <= 4'h0;
    else
      phaseSteps <= stepsNxt;
  end
endmodule // rspctl_phase_map

// [design/rspctl_regs.v]
// rspctl_regs.v: APB register bank for channel-1 respiration control
// assumes APB master on clk; zero-wait answers; unmapped reads give zero, pslverr low
`timescale 1ns/100ps
`include "rspctl_defs.vh"
module rspctl_regs (
  input  wire        clk,
  input  wire        sys_rst,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  output reg         demodulatorEnable,
  output reg         modulatorEnable,
  output reg  [3:0]  demodPhaseSelect,
  output reg         breathClockSourceMode,
  output reg         offsetCalibrationEnable,
  output reg         breathFrequencySelect,
  output reg         driveReferenceSource,
  output reg         breathClockFast,
  output wire [3:0]  demodPhaseSteps
);
  reg  [7:0]  ctlOne_r;
  reg  [7:0]  ctlTwo_r;
  reg  [7:0]  ctlOne_nxt;
  reg  [7:0]  ctlTwo_nxt;
  reg  [31:0] rdata_nxt;
  wire        setup;
  wire        hitOne;
  wire        hitTwo;
  wire        fastNxt;

  // one-cycle access phase: pready rises at the first penable cycle
  assign setup  = psel & ~penable;
  assign hitOne = (paddr == {2'b00, `RSPCTL_IDX_ONE, 2'b00});
  assign hitTwo = (paddr == {2'b00, `RSPCTL_IDX_TWO, 2'b00});
  // external clock mode leaves the rate to the outside source; treated as 32 kHz here
  assign fastNxt = ~ctlOne_nxt[`RSPCTL_ONE_SRC] & ctlTwo_nxt[`RSPCTL_TWO_FREQ];

  always @*
  begin
    ctlOne_nxt = ctlOne_r;
    ctlTwo_nxt = ctlTwo_r;
    if (psel && penable && pready && pwrite)
    begin
      if (hitOne)
        ctlOne_nxt = pwdata[7:0] | `RSPCTL_ONE_FIXMASK;
      if (hitTwo)
        ctlTwo_nxt = (pwdata[7:0] & `RSPCTL_TWO_KEEPMASK) | `RSPCTL_TWO_SETMASK;
    end
  end

  always @*
  begin
    rdata_nxt = 32'h00000000;
    if (hitOne)
      rdata_nxt = {24'h000000, ctlOne_r};
    else if (hitTwo)
      rdata_nxt = {24'h000000, ctlTwo_r};
  end

  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ctlOne_r                <= `RSPCTL_ONE_RESET;
      ctlTwo_r                <= `RSPCTL_TWO_RESET;
      prdata                  <= 32'h00000000;
      pready                  <= 1'b0;
      pslverr                 <= 1'b0;
      demodulatorEnable       <= 1'b0;
      modulatorEnable         <= 1'b0;
      demodPhaseSelect        <= 4'h0;
      breathClockSourceMode   <= 1'b0;
      offsetCalibrationEnable <= 1'b0;
      breathFrequencySelect   <= 1'b0;
      driveReferenceSource    <= 1'b1;
      breathClockFast         <= 1'b0;
    end
    else
    begin
      ctlOne_r                <= ctlOne_nxt;
      ctlTwo_r                <= ctlTwo_nxt;
      pready                  <= setup;
      pslverr                 <= 1'b0;
      if (setup && !pwrite)
        prdata <= rdata_nxt;
      demodulatorEnable       <= ctlOne_nxt[`RSPCTL_ONE_DEMOD];
      modulatorEnable         <= ctlOne_nxt[`RSPCTL_ONE_MOD];
      demodPhaseSelect        <= ctlOne_nxt[`RSPCTL_ONE_PH_HI:`RSPCTL_ONE_PH_LO];
      breathClockSourceMode   <= ctlOne_nxt[`RSPCTL_ONE_SRC];
      offsetCalibrationEnable <= ctlTwo_nxt[`RSPCTL_TWO_CAL];
      breathFrequencySelect   <= ctlTwo_nxt[`RSPCTL_TWO_FREQ];
      driveReferenceSource    <= ctlTwo_nxt[`RSPCTL_TWO_REF];
      breathClockFast         <= fastNxt;
    end
  end

  // step count lags the field outputs by one cycle
  rspctl_phase_map uPhase (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .phaseCode  (demodPhaseSelect),
    .fastClk    (breathClockFast),
    .phaseSteps (demodPhaseSteps)
  );
endmodule // rspctl_regs

// [tb/rspctl_asserts.sv]
// rspctl_asserts.sv: checker for rspctl_regs
// assumes only the top module ports; bound below
`timescale 1ns/100ps
module rspctl_asserts (input wire logic clk, sys_rst, psel, penable, pwrite, pready,
  input wire logic [7:0] paddr, input wire logic [31:0] pwdata, input wire logic demodulatorEnable,
  modulatorEnable, breathClockSourceMode, offsetCalibrationEnable, breathFrequencySelect,
  driveReferenceSource, breathClockFast, input wire logic [3:0] demodPhaseSelect, demodPhaseSteps);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence wr(a); psel && penable && pready && pwrite && paddr == a; endsequence
  a_ready_after_setup: assert property (psel && !penable |=> pready ##1 !pready) else $error("bad ready");
  a_demod_write: assert property (wr(8'h24) |=> demodulatorEnable == $past(pwdata[7])) else $error("demod");
  a_mod_write: assert property (wr(8'h24) |=> modulatorEnable == $past(pwdata[6])) else $error("mod");
  a_phase_write: assert property (wr(8'h24) |=> demodPhaseSelect == $past(pwdata[5:2])) else $error("ph");
  a_mode_write: assert property (wr(8'h24) |=> breathClockSourceMode == $past(pwdata[0])) else $error("src");
  a_two_write: assert property (wr(8'h28) |=> {offsetCalibrationEnable, breathFrequencySelect,
    driveReferenceSource} == {$past(pwdata[7]), $past(pwdata[2:1])}) else $error("two");
  a_fast_map: assert property ($stable({breathClockSourceMode, breathFrequencySelect}) |->
    breathClockFast == (!breathClockSourceMode && breathFrequencySelect)) else $error("fast");
  a_step_map: assert property ($stable({demodPhaseSelect, breathClockFast}) |-> demodPhaseSteps ==
    (breathClockFast ? {demodPhaseSelect[2:0], 1'b0} : demodPhaseSelect)) else $error("steps");
endmodule // rspctl_asserts
bind rspctl_regs rspctl_asserts rspctl_asserts_i (.*);

// [tb/tb.sv]
// tb.sv: register tests for rspctl_regs
// assumes zero-wait apb answers
`timescale 1ns/100ps
`define CHK(a,b) begin checks_done++; if ((a)!==(b)) begin failures++; $display("ERROR %0t %h %h",$time,a,b); end end
module tb;
  logic clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic pready, pslverr, demodulatorEnable, modulatorEnable, breathClockSourceMode, offsetCalibrationEnable;
  logic breathFrequencySelect, driveReferenceSource, breathClockFast;
  logic [3:0] demodPhaseSelect, demodPhaseSteps;
  int failures = 0, checks_done = 0;
  rspctl_regs rspctl_regs_i (.*);
  always #10 clk = ~clk;
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk); psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk); penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata; psel <= 0; penable <= 0;
  endtask
  task automatic stop_test;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (6) @(posedge clk);
    sys_rst <= 0;
    xfer(0, 8'h24, 0); `CHK(rd, 32'h02)
    xfer(0, 8'h28, 0); `CHK(rd, 32'h03)
    `CHK({offsetCalibrationEnable, breathFrequencySelect, driveReferenceSource}, 3'b001)
    xfer(1, 8'h24, 32'hfffffffd); xfer(0, 8'h24, 0); `CHK(rd, 32'hff)
    `CHK({demodulatorEnable, modulatorEnable, demodPhaseSelect, breathClockSourceMode}, 7'h7f)
    xfer(1, 8'h28, 32'hf8); xfer(0, 8'h28, 0); `CHK(rd, 32'h81)
    `CHK({offsetCalibrationEnable, breathFrequencySelect, driveReferenceSource}, 3'b100)
    xfer(1, 8'h2c, 32'hff); xfer(0, 8'h2c, 0); `CHK(rd, 32'h0)
    `CHK(pslverr, 1'b0)
    $display("register test done");
    // mode 0 slow, mode 1 fast, mode 2 external clock stays slow
    for (int k = 0; k < 3; k++)
      for (int c = 0; c < 16; c++)
      begin
        xfer(1, 8'h28, (k != 0) ? 32'h05 : 32'h01);
        xfer(1, 8'h24, {24'h0, 2'b00, c[3:0], 1'b1, k == 2});
        repeat (3) @(posedge clk);
        `CHK(breathClockFast, k == 1)
        `CHK(demodPhaseSteps, (k == 1) ? {c[2:0], 1'b0} : c[3:0])
      end
    $display("phase test done");
    stop_test();
  end
  initial
  begin
    #100us;
    failures++;
    stop_test();
  end
endmodule // tb
